// [core/cpurf_pkg.sv]
// ==========================================================
// core register set constants
package cpurf_pkg;
  // ==========================================================
  // condition flag bit positions
  localparam int CF_CARRY = 0;
  localparam int CF_ZERO = 1;
  localparam int CF_NEG = 2;
  localparam int CF_PRIO_LOW = 3;
  localparam int CF_HALF = 4;
  localparam int CF_PRIO_HIGH = 5;
  // undefined bits of the reset pattern 111x1xxx are taken as zero
  localparam logic [7:0] CF_RESET = 8'he8;
  localparam logic [7:0] CF_FIXED_ONES = 8'hc0;
  // ==========================================================
  // software priority level codes {high, low}
  localparam logic [1:0] PRIO_LEVEL0 = 2'h2;
  localparam logic [1:0] PRIO_LEVEL1 = 2'h1;
  localparam logic [1:0] PRIO_LEVEL2 = 2'h0;
  localparam logic [1:0] PRIO_LEVEL3 = 2'h3;
  // ==========================================================
  // other reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] IDX_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  // ==========================================================
  // conditional relative jump selectors
  typedef enum logic [2:0] {
    CPURF_JUMP_IF_HALF_CARRY,
    CPURF_JUMP_IF_NO_HALF_CARRY,
    CPURF_JUMP_IF_MINUS,
    CPURF_JUMP_IF_PLUS,
    CPURF_JUMP_IF_EQUAL,
    CPURF_JUMP_IF_NOT_EQUAL,
    CPURF_JUMP_IF_CARRY,
    CPURF_JUMP_IF_NO_CARRY
  } cpurf_jump_t;
endpackage

// [core/cpurf_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module cpurf_regs
  import cpurf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic acc_we,
  input wire logic [7:0] acc_wdata,
  input wire logic idx_x_we,
  input wire logic [7:0] idx_x_wdata,
  input wire logic idx_y_we,
  input wire logic [7:0] idx_y_wdata,
  input wire logic pc_we,
  input wire logic [15:0] pc_wdata,
  input wire logic pc_low_we,
  input wire logic [7:0] pc_low_wdata,
  input wire logic pc_high_we,
  input wire logic [7:0] pc_high_wdata,
  input wire logic ctx_restore,
  input wire logic [7:0] ctx_acc,
  input wire logic [7:0] ctx_x,
  input wire logic [15:0] ctx_pc,
  input wire logic [7:0] ctx_flags,
  input wire logic flags_we,
  input wire logic [7:0] flags_wdata,
  input wire logic bit_we,
  input wire logic [2:0] bit_sel,
  input wire logic bit_val,
  input wire logic add_op,
  input wire logic [7:0] add_a,
  input wire logic [7:0] add_b,
  input wire logic add_cin,
  input wire logic result_valid,
  input wire logic [7:0] result,
  input wire logic carry_we,
  input wire logic carry_in,
  input wire logic set_carry_instr,
  input wire logic reset_carry_instr,
  input wire logic irq_entry,
  input wire logic [1:0] irq_soft_priority_regs,
  input wire logic prio_we,
  input wire logic [1:0] prio_wdata,
  input wire logic jump_req,
  input wire logic [2:0] jump_sel,
  output logic [7:0] accumulator,
  output logic [7:0] index_x,
  output logic [7:0] index_y,
  output logic [15:0] program_counter,
  output logic [7:0] condition_flags,
  output logic jump_valid,
  output logic jump_taken
);
  // ==========================================================
  // state
  logic [7:0] acc_r, acc_nxt;
  logic [7:0] x_r, x_nxt;
  logic [7:0] y_r, y_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic [7:0] cf_r, cf_nxt;
  logic jv_r, jv_nxt;
  logic jt_r, jt_nxt;
  logic [4:0] half_sum;
  cpurf_jump_t jsel;

  assign half_sum = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};
  assign jsel = cpurf_jump_t'(jump_sel);

  // data registers next values
  always_comb begin
    acc_nxt = acc_r;
    x_nxt = x_r;
    y_nxt = y_r;
    pc_nxt = pc_r;
    if (acc_we) begin
      acc_nxt = acc_wdata;
    end
    if (idx_x_we) begin
      x_nxt = idx_x_wdata;
    end
    if (idx_y_we) begin
      y_nxt = idx_y_wdata;
    end
    if (pc_we) begin
      pc_nxt = pc_wdata;
    end
    if (pc_low_we) begin
      pc_nxt[7:0] = pc_low_wdata;
    end
    if (pc_high_we) begin
      pc_nxt[15:8] = pc_high_wdata;
    end
    // restore leaves the second index register alone
    if (ctx_restore) begin
      acc_nxt = ctx_acc;
      x_nxt = ctx_x;
      pc_nxt = ctx_pc;
    end
  end

  // condition flags next value, restore or whole write blocks the single field steps other than interrupt entry, among which later steps override earlier ones
  always_comb begin
    cf_nxt = cf_r;
    if (ctx_restore) begin
      cf_nxt = ctx_flags | CF_FIXED_ONES;
    end else if (flags_we) begin
      cf_nxt = flags_wdata | CF_FIXED_ONES;
    end else begin
      if (bit_we && bit_sel < 3'h6) begin
        cf_nxt[bit_sel] = bit_val;
      end
      if (add_op) begin
        cf_nxt[CF_HALF] = half_sum[4];
      end
      if (result_valid) begin
        cf_nxt[CF_NEG] = result[7];
        cf_nxt[CF_ZERO] = (result == 8'h00);
      end
      if (carry_we) begin
        cf_nxt[CF_CARRY] = carry_in;
      end
      if (reset_carry_instr) begin
        cf_nxt[CF_CARRY] = 1'b0;
      end
      if (set_carry_instr) begin
        cf_nxt[CF_CARRY] = 1'b1;
      end
      if (prio_we) begin
        {cf_nxt[CF_PRIO_HIGH], cf_nxt[CF_PRIO_LOW]} = prio_wdata;
      end
    end
    // interrupt entry wins over every software priority write
    if (irq_entry) begin
      {cf_nxt[CF_PRIO_HIGH], cf_nxt[CF_PRIO_LOW]} = irq_soft_priority_regs;
    end
  end

  // conditional jump evaluation on the current flags
  always_comb begin
    jv_nxt = jump_req;
    jt_nxt = 1'b0;
    unique case (jsel)
      CPURF_JUMP_IF_HALF_CARRY: jt_nxt = cf_r[CF_HALF];
      CPURF_JUMP_IF_NO_HALF_CARRY: jt_nxt = ~cf_r[CF_HALF];
      CPURF_JUMP_IF_MINUS: jt_nxt = cf_r[CF_NEG];
      CPURF_JUMP_IF_PLUS: jt_nxt = ~cf_r[CF_NEG];
      CPURF_JUMP_IF_EQUAL: jt_nxt = cf_r[CF_ZERO];
      CPURF_JUMP_IF_NOT_EQUAL: jt_nxt = ~cf_r[CF_ZERO];
      CPURF_JUMP_IF_CARRY: jt_nxt = cf_r[CF_CARRY];
      CPURF_JUMP_IF_NO_CARRY: jt_nxt = ~cf_r[CF_CARRY];
    endcase
    if (!jump_req) begin
      jt_nxt = 1'b0;
    end
  end

  // registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      acc_r <= ACC_RESET;
      x_r <= IDX_RESET;
      y_r <= IDX_RESET;
      pc_r <= PC_RESET;
      cf_r <= CF_RESET;
      jv_r <= 1'b0;
      jt_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      x_r <= x_nxt;
      y_r <= y_nxt;
      pc_r <= pc_nxt;
      cf_r <= cf_nxt;
      jv_r <= jv_nxt;
      jt_r <= jt_nxt;
    end
  end

  assign accumulator = acc_r;
  assign index_x = x_r;
  assign index_y = y_r;
  assign program_counter = pc_r;
  assign condition_flags = cf_r;
  assign jump_valid = jv_r;
  assign jump_taken = jt_r;

  // ==========================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  acc_write_a: assert property (acc_we && !ctx_restore |=> acc_r == $past(acc_wdata))
    else $error("accumulator write lost");
  y_keep_a: assert property (ctx_restore && !idx_y_we |=> y_r == $past(y_r))
    else $error("second index changed by restore");
  pc_high_a: assert property (pc_high_we && !ctx_restore |=> pc_r[15:8] == $past(pc_high_wdata))
    else $error("pc high byte write lost");
  reset_flags_a: assert property ($fell(srst) |-> cf_r[7:5] == 3'h7 && cf_r[3])
    else $error("flag reset pattern wrong");
  half_carry_a: assert property (add_op && !ctx_restore && !flags_we
    |=> cf_r[CF_HALF] == (($past(add_a[3:0]) + $past(add_b[3:0]) + $past(add_cin)) > 5'd15))
    else $error("half carry wrong");
  neg_zero_a: assert property (result_valid && !ctx_restore && !flags_we
    |=> cf_r[CF_NEG] == $past(result[7]) && cf_r[CF_ZERO] == ($past(result) == 8'h00))
    else $error("negative or zero flag wrong");
  set_carry_a: assert property (set_carry_instr && !ctx_restore && !flags_we |=> cf_r[CF_CARRY])
    else $error("set carry ignored");
  clr_carry_a: assert property (reset_carry_instr && !set_carry_instr && !ctx_restore && !flags_we
    |=> !cf_r[CF_CARRY])
    else $error("reset carry ignored");
  jump_eq_a: assert property (jump_req && jump_sel == 3'h4 |=> jump_valid && jump_taken == $past(cf_r[CF_ZERO]))
    else $error("equal jump misjudged");
  irq_prio_a: assert property (irq_entry |=> {cf_r[CF_PRIO_HIGH], cf_r[CF_PRIO_LOW]} == $past(irq_soft_priority_regs))
    else $error("entry priority not loaded");
  idle_keep_a: assert property (!(ctx_restore || flags_we || bit_we || add_op || result_valid || carry_we
    || set_carry_instr || reset_carry_instr || irq_entry || prio_we) |=> $stable(cf_r))
    else $error("flags changed without cause");

  cov_add_c: cover property (add_op && result_valid ##1 cf_r[CF_HALF]);
  cov_irq_c: cover property (irq_entry ##1 ctx_restore);
  cov_jump_c: cover property (jump_req ##1 jump_taken);
endmodule
`default_nettype wire

// [verification/cpurf_alu_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// alu model: one add or adc result for each go cycle
module cpurf_alu_model
  import cpurf_pkg::*;
(
  input wire logic go,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  output logic add_op,
  output logic [7:0] add_a,
  output logic [7:0] add_b,
  output logic add_cin,
  output logic result_valid,
  output logic [7:0] result,
  output logic carry_we,
  output logic carry_in
);
  logic [8:0] sum;
  // operands invert when idle so stale values never look valid
  always_comb begin
    sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    add_op = go;
    add_a = go ? a : ~a;
    add_b = go ? b : ~b;
    add_cin = go ? cin : ~cin;
    result_valid = go;
    result = go ? sum[7:0] : ~sum[7:0];
    carry_we = go;
    carry_in = go ? sum[8] : ~sum[8];
  end
endmodule
`default_nettype wire

// [verification/cpurf_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// register set bench
module cpurf_regs_tb;
  import cpurf_pkg::*;
  logic ref_clk = 1'b0, srst = 1'b1, alu_go = 1'b0, alu_cin = 1'b0;
  logic [7:0] alu_a = 8'h00, alu_b = 8'h00;
  logic acc_we, idx_x_we, idx_y_we, pc_we, pc_low_we, pc_high_we, ctx_restore, flags_we, bit_we, bit_val;
  logic set_carry_instr, reset_carry_instr, irq_entry, prio_we, jump_req, add_op, add_cin, result_valid;
  logic carry_we, carry_in, jump_valid, jump_taken;
  logic [7:0] acc_wdata, idx_x_wdata, idx_y_wdata, pc_low_wdata, pc_high_wdata, ctx_acc, ctx_x, ctx_flags;
  logic [7:0] flags_wdata, add_a, add_b, result, accumulator, index_x, index_y, condition_flags;
  logic [15:0] pc_wdata, ctx_pc, program_counter;
  logic [2:0] bit_sel, jump_sel;
  logic [1:0] irq_soft_priority_regs, prio_wdata;
  logic [7:0] f;
  int fails = 0, num_checks = 0;
  // add rows: a, b, carry in, expected low flags
  logic [24:0] rows [5] = '{{8'h08, 8'h08, 1'b0, 8'h10}, {8'hff, 8'h01, 1'b0, 8'h13},
    {8'h7f, 8'h01, 1'b0, 8'h14}, {8'h10, 8'h20, 1'b1, 8'h00}, {8'h0f, 8'h00, 1'b1, 8'h10}};
  always #2 ref_clk = ~ref_clk;
  cpurf_regs dut (.*);
  cpurf_alu_model alu (.go(alu_go), .a(alu_a), .b(alu_b), .cin(alu_cin), .*);
  // ==========================================================
  // compare and report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one cycle; strobes dropped after the taking edge unless held up for a back-to-back run
  task automatic tick(input bit hold = 1'b0);
    @(negedge ref_clk);
    if (!hold) begin
      {acc_we, idx_x_we, idx_y_we, pc_we, pc_low_we, pc_high_we, ctx_restore, flags_we, bit_we} = '0;
      {set_carry_instr, reset_carry_instr, irq_entry, prio_we, jump_req, alu_go} = '0;
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {acc_wdata, idx_x_wdata, idx_y_wdata, pc_low_wdata, pc_high_wdata, ctx_acc, ctx_x, ctx_flags} = '0;
    {flags_wdata, pc_wdata, ctx_pc, bit_sel, jump_sel, irq_soft_priority_regs, prio_wdata, bit_val} = '0;
    tick();
    repeat (20) @(negedge ref_clk);
    srst = 1'b0;
    chk(16'(condition_flags), 16'h00e8);
    chk({accumulator, index_y}, 16'h0000);
    // add rows back to back with the alu strobe held up
    alu_go = 1'b1;
    foreach (rows[i]) begin
      {alu_a, alu_b, alu_cin} = rows[i][24:8];
      tick(i < 4);
      chk(16'(condition_flags & 8'h17), 16'(rows[i][7:0]));
    end
    f = condition_flags;
    acc_we = 1'b1;
    acc_wdata = 8'h5a;
    idx_x_we = 1'b1;
    idx_x_wdata = 8'h11;
    idx_y_we = 1'b1;
    idx_y_wdata = 8'h33;
    tick();
    chk({accumulator, index_x}, 16'h5a11);
    chk({index_y, condition_flags}, {8'h33, f});
    ctx_restore = 1'b1;
    ctx_acc = 8'ha5;
    ctx_x = 8'h22;
    ctx_pc = 16'h1234;
    ctx_flags = 8'hc5;
    tick();
    chk({accumulator, index_x}, 16'ha522);
    chk({index_y, condition_flags}, 16'h33c5);
    pc_low_we = 1'b1;
    pc_low_wdata = 8'haa;
    tick();
    chk(program_counter, 16'h12aa);
    pc_high_we = 1'b1;
    pc_high_wdata = 8'h55;
    tick();
    chk(program_counter, 16'h55aa);
    // whole load with the low byte strobe beside it: the byte wins
    pc_we = 1'b1;
    pc_wdata = 16'h4321;
    pc_low_we = 1'b1;
    pc_low_wdata = 8'h99;
    tick();
    chk(program_counter, 16'h4399);
    // carry is already set after the restore, so clear it first and then set it
    reset_carry_instr = 1'b1;
    tick();
    chk(16'(condition_flags[0]), 16'h0000);
    set_carry_instr = 1'b1;
    tick();
    chk(16'(condition_flags[0]), 16'h0001);
    bit_we = 1'b1;
    bit_sel = 3'h1;
    bit_val = 1'b1;
    tick();
    chk(16'(condition_flags), 16'h00c7);
    flags_we = 1'b1;
    flags_wdata = 8'h3a;
    tick();
    chk(16'(condition_flags), 16'h00fa);
    // a single bit write aimed at a fixed bit is ignored
    bit_we = 1'b1;
    bit_sel = 3'h7;
    bit_val = 1'b0;
    tick();
    chk(16'(condition_flags), 16'h00fa);
    // software levels back to back with the write strobe held up
    prio_we = 1'b1;
    for (int l = 0; l < 4; l++) begin
      prio_wdata = (l == 0) ? PRIO_LEVEL0 : (l == 1) ? PRIO_LEVEL1 : (l == 2) ? PRIO_LEVEL2 : PRIO_LEVEL3;
      tick(1'b1);
      chk(16'({condition_flags[5], condition_flags[3]}), 16'(prio_wdata));
    end
    // entry beside the still held software write: entry wins
    irq_entry = 1'b1;
    irq_soft_priority_regs = 2'h1;
    prio_wdata = 2'h2;
    tick();
    chk(16'({condition_flags[5], condition_flags[3]}), 16'h0001);
    f = condition_flags;
    // every jump test back to back with the request held up
    jump_req = 1'b1;
    for (int s = 0; s < 8; s++) begin
      jump_sel = s[2:0];
      tick(s < 7);
      chk(16'({jump_valid, jump_taken}), 16'({1'b1, f[(s < 2) ? 4 : (s < 4) ? 2 : (s < 6) ? 1 : 0] ^ s[0]}));
    end
    tick();
    chk(16'({jump_valid, jump_taken}), 16'h0000);
    // reset again in mid-run, then one idle cycle after release
    srst = 1'b1;
    tick();
    tick();
    chk({condition_flags, accumulator}, 16'he800);
    srst = 1'b0;
    tick();
    chk({condition_flags, index_y}, 16'he800);
    final_report();
  end
endmodule
`default_nettype wire
